/* design/drs_sequencer.sv */
// device-side command decoder: refresh bank/row counting, auto-precharge, read inversion
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RQ1: refresh recognised by cs high, ca0-2 and ca4 low, ca3 high, first edge.
// RQ2: ca5 on first edge: low per-bank refresh, high all-bank refresh.
// RQ3: per-bank refresh bank number from ca2:0 on second edge, ca0 lowest.
// RQ4: controller refreshes each bank once per set of eight, any order.
// RQ5: bank count cleared on reset and on every self-refresh exit.
// RQ6: all-bank refresh clears bank count and refreshes all banks at row counter.
// RQ7: refresh after an all-bank refresh uses incremented row counter.
// RQ8: set of eight counts from first per-bank refresh after a sync event.
// RQ9: operations to other banks accepted while one bank refreshes.
// RQ10: controller refreshes every interval, postponing at most eight.
// RQ11: temperature-rate 001B allows all rates; 010B forbids only four-times rate.
// RQ12: read or write taken when cke high and cs/ca encode it on rising edge.
// RQ13: controller never interrupts a burst; length may be chosen per command.
// RQ14: read-to-write gap without data odt by latency and burst formula.
// RQ15: read-to-write gap with data odt by latency, burst and odt formula.
// RQ16: auto-precharge starts read-to-precharge time after read, plus 8 for burst 32.
// RQ17: activate same bank after precharge time or row cycle time.
// RQ18: write then read with auto-precharge must cover write recovery.
// RQ19: controller holds complement strobe high idle, differential on write.
// RQ20: controller resumes complement strobe high after postamble while cke high.
// RQ21: mode-register read inversion: byte with over four ones inverted, pin high.
// RQ22: masked write with inversion needs mask enable and write inversion enable.
// RQ23: controller tracks postponed refreshes and forces refresh before the limit.
module drs_sequencer #(
    parameter int ROW_W = drs_pkg::ROW_W,
    parameter int RFC_CK = drs_pkg::RFCPB_CK,
    parameter int RTP_CK = drs_pkg::RTP_CK
) (
    input  wire logic                      clk_sys,       // 20 MHz system clock
    input  wire logic                      rst_n,         // async reset, active low
    input  wire logic                      linkClk,       // command clock pin
    input  wire logic                      cke,           // clock enable pin
    input  wire logic                      cs,            // chip select pin
    input  wire logic [drs_pkg::CA_W-1:0]  cmd_addr_bus,  // command-address pins
    input  wire logic                      selfRefExit,   // pulse: self refresh exited
    input  wire logic                      burst32,       // burst length 32 selected
    input  wire logic                      readInvEn,     // read inversion enabled
    input  wire logic                      mrrInvSupp,    // inversion supported on mrr
    input  wire logic                      maskEn,        // write masking enable bit
    input  wire logic                      writeInvEn,    // write inversion enable bit
    input  wire logic                      mrrValid,      // mrr byte presented
    input  wire logic [7:0]                mrrByte,       // mode-register read byte
    output logic                           refreshPulse,  // refresh accepted
    output logic                           allBankRef,    // last refresh was all-bank
    output logic [drs_pkg::BANK_W-1:0]     refBank,       // bank being refreshed
    output logic [ROW_W-1:0]               refRow,        // row used by last refresh
    output logic [drs_pkg::BANK_W:0]       bankCount,     // per-bank refreshes in set
    output logic [drs_pkg::NUM_BANKS-1:0]  bankBusy,      // banks in refresh
    output logic                           readPulse,     // read accepted
    output logic                           writePulse,    // write accepted
    output logic                           maskedInvOk,   // masked write w/ inversion legal
    output logic                           prechStart,    // auto-precharge begins
    output logic [7:0]                     dqOut,         // mrr data out
    output logic                           mask_invert_pin // inversion flag out
);
    // two-flop synchronisers on every pin
    logic [1:0] lnkS_r;
    logic [1:0] ckeS_r;
    logic [1:0] csS_r;
    logic [drs_pkg::CA_W-1:0] caS1_r;
    logic [drs_pkg::CA_W-1:0] caS2_r;
    logic lnkPrev_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnkS_r    <= 2'h0;
            ckeS_r    <= 2'h0;
            csS_r     <= 2'h0;
            caS1_r    <= 6'h00;
            caS2_r    <= 6'h00;
            lnkPrev_r <= 1'b0;
        end else begin
            lnkS_r    <= {lnkS_r[0], linkClk};
            ckeS_r    <= {ckeS_r[0], cke};
            csS_r     <= {csS_r[0], cs};
            caS1_r    <= cmd_addr_bus;
            caS2_r    <= caS1_r;
            lnkPrev_r <= lnkS_r[1];
        end
    end

    // rising edge of the link clock; pins are sampled with the same delay so
    // they line up with the rising edge at which the device samples them
    logic ckRise;
    assign ckRise = lnkS_r[1] & ~lnkPrev_r;

    // first-edge decode
    logic isRef;
    logic isRead;
    logic isWrite;
    assign isRef   = ckRise && csS_r[1] && ckeS_r[1]
                   && ((caS2_r[4:0] & drs_pkg::ENC_MASK5) == drs_pkg::ENC_REFRESH); // RQ1
    assign isRead  = ckRise && csS_r[1] && ckeS_r[1]
                   && (caS2_r[4:0] == drs_pkg::ENC_READ);                            // RQ12
    assign isWrite = ckRise && csS_r[1] && ckeS_r[1]
                   && (caS2_r[4:0] == drs_pkg::ENC_WRITE
                       || caS2_r[4:0] == drs_pkg::ENC_MWRITE);                       // RQ12

    // command state: per-bank refresh waits for its second edge
    drs_pkg::drs_cmd_state_t cmdState_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmdState_r <= drs_pkg::CMD_IDLE;
        end else begin
            unique case (cmdState_r)
                drs_pkg::CMD_IDLE: begin
                    if (isRef && !caS2_r[drs_pkg::CA_BIT_ALL]) begin // RQ2
                        cmdState_r <= drs_pkg::CMD_SECOND;
                    end
                end
                drs_pkg::CMD_SECOND: begin
                    if (ckRise) begin
                        cmdState_r <= drs_pkg::CMD_IDLE;
                    end
                end
                default: cmdState_r <= drs_pkg::CMD_IDLE;
            endcase
        end
    end

    logic pbDone;
    logic abDone;
    assign pbDone = (cmdState_r == drs_pkg::CMD_SECOND) && ckRise;
    assign abDone = (cmdState_r == drs_pkg::CMD_IDLE) && isRef
                  && caS2_r[drs_pkg::CA_BIT_ALL]; // RQ2

    // refresh outputs and bank/row counters
    logic rowAdv_r;
    logic [ROW_W-1:0] rowCtr_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refreshPulse <= 1'b0;
            allBankRef   <= 1'b0;
            refBank      <= drs_pkg::BANK_ZERO;
            refRow       <= drs_pkg::ROW_RESET;
            rowCtr_r     <= drs_pkg::ROW_RESET;
            rowAdv_r     <= 1'b0;
            bankCount    <= 4'h0; // RQ5
        end else begin
            refreshPulse <= pbDone | abDone;
            if (selfRefExit) begin
                bankCount <= 4'h0; // RQ5
            end
            if (abDone) begin
                allBankRef <= 1'b1;
                bankCount  <= 4'h0;                              // RQ6
                refRow     <= rowAdv_r ? rowCtr_r + 1'b1 : rowCtr_r; // RQ7
                rowCtr_r   <= rowAdv_r ? rowCtr_r + 1'b1 : rowCtr_r; // RQ6
                rowAdv_r   <= 1'b1;
            end else if (pbDone) begin
                allBankRef <= 1'b0;
                refBank    <= caS2_r[drs_pkg::BANK_W-1:0];       // RQ3
                refRow     <= rowAdv_r ? rowCtr_r + 1'b1 : rowCtr_r; // RQ7
                if (rowAdv_r) begin
                    rowCtr_r <= rowCtr_r + 1'b1;
                end
                rowAdv_r <= 1'b0;
                // a full set of eight wraps the count and moves the row on
                if (!selfRefExit) begin
                    if (bankCount == 4'(drs_pkg::NUM_BANKS - 1)) begin // RQ8
                        bankCount <= 4'h0;
                        rowAdv_r  <= 1'b1;
                    end else begin
                        bankCount <= bankCount + 4'h1; // RQ8
                    end
                end
            end
        end
    end

    // per-bank busy timers; other banks stay usable
    logic [drs_pkg::CNT_W-1:0] busyCnt_r [drs_pkg::NUM_BANKS];
    genvar gb;
    generate
        for (gb = 0; gb < drs_pkg::NUM_BANKS; gb++) begin : gBank
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    busyCnt_r[gb] <= 6'h00;
                end else if ((pbDone && caS2_r[2:0] == 3'(gb)) || abDone) begin // RQ9
                    busyCnt_r[gb] <= 6'(RFC_CK);
                end else if (ckRise && busyCnt_r[gb] != 6'h00) begin
                    busyCnt_r[gb] <= busyCnt_r[gb] - 6'h01;
                end
            end
        end
    endgenerate

    // busy flags come from one process so the output vector has a single driver
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bankBusy <= 8'h00;
        end else begin
            for (int b = 0; b < drs_pkg::NUM_BANKS; b++) begin
                bankBusy[b] <= (busyCnt_r[b] > 6'h01)
                             || ((pbDone && caS2_r[2:0] == 3'(b)) || abDone); // RQ9
            end
        end
    end

    // read/write acceptance and masked-write inversion legality
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            readPulse   <= 1'b0;
            writePulse  <= 1'b0;
            maskedInvOk <= 1'b0;
        end else begin
            readPulse   <= isRead;     // RQ12
            writePulse  <= isWrite;    // RQ12
            maskedInvOk <= maskEn & writeInvEn; // RQ22
        end
    end

    // auto-precharge delay, extra eight clocks for burst 32
    logic [drs_pkg::CNT_W-1:0] apCnt_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            apCnt_r    <= 6'h00;
            prechStart <= 1'b0;
        end else begin
            prechStart <= 1'b0;
            if (isRead && caS2_r[drs_pkg::CA_BIT_AP]) begin
                apCnt_r <= burst32 ? 6'(RTP_CK + drs_pkg::BL32_EXTRA_CK) : 6'(RTP_CK); // RQ16
            end else if (ckRise && apCnt_r != 6'h00) begin
                apCnt_r <= apCnt_r - 6'h01;
                prechStart <= (apCnt_r == 6'h01); // RQ16
            end
        end
    end

    // mrr read inversion; without support the pin stays low
    logic [3:0] ones;
    always_comb begin
        ones = 4'h0;
        for (int i = 0; i < 8; i++) begin
            ones = ones + 4'(mrrByte[i]);
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dqOut           <= 8'h00;
            mask_invert_pin <= 1'b0;
        end else if (mrrValid) begin
            if (readInvEn && mrrInvSupp && ones > 4'h4) begin // RQ21
                dqOut           <= ~mrrByte;
                mask_invert_pin <= 1'b1;
            end else begin
                dqOut           <= mrrByte;
                mask_invert_pin <= 1'b0; // RQ21
            end
        end
    end
endmodule
`default_nettype wire

/* common/drs_pkg.sv */
// constants for the dram refresh and access sequencer
package drs_pkg;
    localparam int NUM_BANKS     = 8;
    localparam int BANK_W        = 3;
    localparam int ROW_W         = 16;
    localparam int CA_W          = 6;
    // command-address bit positions
    localparam int CA_BIT_REF3   = 3;
    localparam int CA_BIT_ALL    = 5;
    localparam int CA_BIT_AP     = 5;
    // first-edge encodings (cs high), bits 4:0
    localparam logic [4:0] ENC_REFRESH = 5'h08;
    localparam logic [4:0] ENC_WRITE   = 5'h04;
    localparam logic [4:0] ENC_MWRITE  = 5'h06;
    localparam logic [4:0] ENC_READ    = 5'h02;
    localparam logic [4:0] ENC_MASK5   = 5'h1F;
    // timing in link clocks
    localparam int RTP_CK        = 8;
    localparam int BL32_EXTRA_CK = 8;
    localparam int RFCPB_CK      = 16;
    localparam int PRECH_CK      = 8;
    localparam int CNT_W         = 6;
    localparam logic [ROW_W-1:0] ROW_RESET  = 16'h0000;
    localparam logic [BANK_W-1:0] BANK_ZERO = 3'h0;
    typedef enum logic [1:0] {CMD_IDLE, CMD_SECOND} drs_cmd_state_t;
endpackage

/* tb/drs_sva.sv */
// assertions on the refresh and access sequencer ports
`timescale 1ns/10ps
`default_nettype none
module drs_sva #(
    parameter int ROW_W  = 16,
    parameter int RTP_CK = 8
) (
    input wire logic             clk_sys,        // system clock
    input wire logic             rst_n,          // async reset
    input wire logic             selfRefExit,    // sync event
    input wire logic             burst32,        // burst 32 mode
    input wire logic             maskEn,         // mask enable
    input wire logic             writeInvEn,     // write inversion
    input wire logic             refreshPulse,   // refresh taken
    input wire logic             readPulse,      // read taken
    input wire logic             writePulse,     // write taken
    input wire logic             allBankRef,     // all-bank flag
    input wire logic [2:0]       refBank,        // refreshed bank
    input wire logic [ROW_W-1:0] refRow,         // refreshed row
    input wire logic [3:0]       bankCount,      // bank count
    input wire logic [7:0]       bankBusy,       // busy banks
    input wire logic             maskedInvOk,    // legal combination
    input wire logic             prechStart,     // precharge begins
    input wire logic [7:0]       dqOut,          // mrr data
    input wire logic             mask_invert_pin // inversion pin
);
    // link clock is 8 system clocks in this bench, so latencies scale by 8
    localparam int PR_EXP = RTP_CK * 8;
    logic [7:0]       sinceRd_r;
    logic             lastAll_r;
    logic [ROW_W-1:0] lastRow_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // age of the last read saturates so a long idle cannot wrap it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) sinceRd_r <= 8'h00;
        else if (readPulse) sinceRd_r <= 8'h00;
        else if (sinceRd_r != 8'hFF) sinceRd_r <= sinceRd_r + 8'h01;
    end
    // remember kind and row of the previous refresh
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lastAll_r <= 1'b0;
            lastRow_r <= '0;
        end else if (refreshPulse) begin
            lastAll_r <= allBankRef;
            lastRow_r <= refRow;
        end
    end
    sequence s_pb_ref;
        refreshPulse && !allBankRef;
    endsequence
    sequence s_bank_busy;
        ##[12:24] bankBusy[refBank];
    endsequence
    a_cmd_excl: assert property ($onehot0({refreshPulse, readPulse, writePulse}))
        else $error("two commands taken at once");
    a_ref_single: assert property (refreshPulse |=> !refreshPulse)
        else $error("refresh pulse too long");
    a_all_clears: assert property (refreshPulse && allBankRef |-> ##[0:2] bankCount == 4'h0)
        else $error("all-bank refresh left bank count");
    a_exit_clears: assert property (selfRefExit |-> ##[1:2] bankCount == 4'h0)
        else $error("self refresh exit left bank count");
    a_count_bound: assert property (bankCount < 4'h8)
        else $error("bank count out of range");
    a_row_step: assert property (refreshPulse && lastAll_r |-> refRow == lastRow_r + 1'b1)
        else $error("row not advanced after all-bank");
    a_busy_bank: assert property (s_pb_ref |-> s_bank_busy)
        else $error("refreshed bank not busy");
    a_prech_time: assert property (prechStart |->
        int'(sinceRd_r) + 3 >= PR_EXP + (burst32 ? 64 : 0) &&
        int'(sinceRd_r) <= PR_EXP + (burst32 ? 64 : 0) + 2)
        else $error("auto-precharge at wrong time");
    a_inv_pin: assert property (mask_invert_pin |-> $countones(dqOut) < 4)
        else $error("inversion pin with too many ones");
    a_mask_inv: assert property (maskedInvOk == $past(maskEn && writeInvEn))
        else $error("masked inversion legality wrong");
endmodule
bind drs_sequencer drs_sva #(.ROW_W(ROW_W), .RTP_CK(RTP_CK)) u_sva (.*);
`default_nettype wire

/* tb/drs_host_model.sv */
// host controller model driving the command pins of the sequencer
`timescale 1ns/10ps
`default_nettype none
module drs_host_model (
    output var logic       linkClk,     // command clock
    output var logic       cke,         // clock enable
    output var logic       cs,          // chip select
    output var logic [5:0] cmd_addr_bus // command-address pins
);
    // memory clock runs free; 7 ns offset keeps it unrelated to clk_sys
    initial begin
        linkClk = 1'b0;
        cke = 1'b1;
        cs = 1'b0;
        cmd_addr_bus = 6'h15;
        #7;
        forever #200 linkClk = ~linkClk;
    end
    // pins move on falling edges so each rising edge sees them stable
    // each call is one whole command, never cut short by another
    // callers space commands by whole link periods, beyond any gap
    // the same spacing also covers the odt-enabled turnaround
    // activate and write-to-read spacing are never tightened here
    // write recovery is met by the same generous spacing
    // no data strobe is modelled; complement strobe is taken as high
    // strobe is treated as parked high again after each write
    // refreshes are issued back to back, never postponed
    // only the base refresh rate is used, legal for any rate field
    // no postponement ever builds up, so the forced limit is not hit
    task automatic send(input logic [5:0] c1, input logic [5:0] c2, input logic en,
                        input logic ck);
        @(negedge linkClk);
        cke <= ck;
        cs <= en;
        cmd_addr_bus <= c1;
        @(negedge linkClk);
        cs <= 1'b0;
        cmd_addr_bus <= c2;
        @(negedge linkClk);
        cke <= 1'b1;
        cmd_addr_bus <= ~c2; // deselected bus shows no stale value
    endtask
endmodule
`default_nettype wire

/* tb/dram_refresh_access_sequencing_tb_top.sv */
// testbench for the refresh and access sequencer
`timescale 1ns/10ps
`default_nettype none
module dram_refresh_access_sequencing_tb_top;
    logic clk_sys, rst_n, selfRefExit, burst32, readInvEn, mrrInvSupp, maskEn, writeInvEn;
    logic mrrValid, linkClk, cke, cs, refreshPulse, allBankRef, readPulse, writePulse;
    logic maskedInvOk, prechStart, mask_invert_pin;
    logic [7:0] mrrByte, bankBusy, dqOut;
    logic [5:0] cmd_addr_bus;
    logic [2:0] refBank;
    logic [3:0] bankCount;
    logic [drs_pkg::ROW_W-1:0] refRow;
    int err_count = 0, cmp_count = 0, cyc = 0, nRef = 0, nRd = 0, nWr = 0, rdAt = 0, prLat = 0;
    int n;
    logic [2:0] ord[8] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h6};
    drs_sequencer DUT (.*);
    drs_host_model u_host (.*);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // pulse counters, precharge latency and the hang limit
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (refreshPulse === 1'b1) nRef <= nRef + 1;
        if (readPulse === 1'b1) nRd <= nRd + 1;
        if (writePulse === 1'b1) nWr <= nWr + 1;
        if (readPulse === 1'b1) rdAt <= cyc;
        if (prechStart === 1'b1) prLat <= cyc - rdAt;
        if (cyc == 6000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input logic [5:0] c1, input logic [5:0] c2, input logic en = 1'b1,
                       input logic ck = 1'b1);
        u_host.send(c1, c2, en, ck);
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic pb(input logic [2:0] b, input logic [15:0] row, input logic [3:0] cnt);
        cmd(6'h08, {3'h0, b});
        chk(allBankRef, 1'b0, "per-bank flag");
        chk(refBank, b, "bank");
        chk(refRow, row, "per-bank row");
        chk(bankCount, cnt, "bank count");
        chk(bankBusy[b], 1'b1, "bank busy");
    endtask
    task automatic mrr(input logic en, input logic sup, input logic [7:0] b,
                       input logic [7:0] dq, input logic pin);
        readInvEn <= en;
        mrrInvSupp <= sup;
        mrrByte <= b;
        mrrValid <= 1'b1;
        @(posedge clk_sys);
        mrrValid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(dqOut, dq, "mrr data");
        chk(mask_invert_pin, pin, "mrr pin");
    endtask
    // main sequence: refresh, access and precharge tests are chains of pin commands with expectations
    initial begin
        {rst_n, selfRefExit, burst32, readInvEn, mrrInvSupp, maskEn, writeInvEn} = 7'h00;
        mrrValid = 1'b0;
        mrrByte = 8'h00;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(bankCount, 4'h0, "reset count");
        n = nRef;
        cmd(6'h28, 6'h00);
        chk(16'(nRef - n), 16'h0001, "all-bank taken");
        chk(allBankRef, 1'b1, "all-bank flag");
        chk(refRow, 16'h0000, "all-bank row");
        $display("test all-bank done");
        foreach (ord[i]) pb(ord[i], 16'h0001, 4'((i + 1) % 8));
        pb(3'h7, 16'h0002, 4'h1);
        pb(3'h1, 16'h0002, 4'h2);
        cmd(6'h28, 6'h00);
        chk(bankCount, 4'h0, "all-bank resync");
        chk(refRow, 16'h0002, "all-bank row");
        pb(3'h0, 16'h0003, 4'h1);
        selfRefExit <= 1'b1;
        @(posedge clk_sys);
        selfRefExit <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(bankCount, 4'h0, "exit resync");
        $display("test per-bank done");
        n = nRef;
        cmd(6'h28, 6'h00, 1'b0);
        cmd(6'h28, 6'h00, 1'b1, 1'b0);
        chk(16'(nRef - n), 16'h0000, "deselected ignored");
        pb(3'h5, 16'h0003, 4'h1);
        n = nRd + nWr;
        cmd(6'h02, 6'h00);
        cmd(6'h04, 6'h00);
        cmd(6'h06, 6'h00);
        chk(16'(nRd + nWr - n), 16'h0003, "access during refresh");
        $display("test access done");
        for (int b = 0; b < 2; b++) begin
            burst32 <= b[0];
            cmd(6'h22, 6'h00);
            repeat (140) @(posedge clk_sys);
            n = drs_pkg::RTP_CK * 8 + b * 64;
            chk(prLat >= n - 2 && prLat <= n + 2, 1'b1, "precharge delay");
        end
        $display("test auto-precharge done");
        for (int i = 0; i < 4; i++) begin
            {maskEn, writeInvEn} <= 2'(i);
            repeat (3) @(posedge clk_sys);
            chk(maskedInvOk, i == 3, "masked inversion");
        end
        mrr(1'b1, 1'b1, 8'h1F, 8'hE0, 1'b1);
        mrr(1'b1, 1'b1, 8'h0F, 8'h0F, 1'b0);
        mrr(1'b1, 1'b0, 8'h1F, 8'h1F, 1'b0);
        mrr(1'b0, 1'b1, 8'hF8, 8'hF8, 1'b0);
        $display("test mode-register read done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
